// ---- hdl/sca_pkg.sv ----
// Constants for the switched-capacitor type A switch control block
//
// Overview of operation
// R1: B-branch size field is binary; value equals unit capacitors switched in, 0 to 31.
// R2: First control registers at indices 81h, 89h, 95h, 9Dh, same in both banks.
// R3: Column bus enable bit 7 clear tri-states the column bus drive.
// R4: Enabled column drive: last part of second phase, or continuous when phase swapped.
// R5: Comparator reaches comparator bus only while bit 6 is set.
// R6: Comparator bus reads low when no block in the column drives it.
// R7: Comparator sampled on internal first phase rise, held through second phase.
// R8: Offset null off: shorting switch open, branches always on amplifier input.
// R9: Offset null on: short and ground branches in first phase, amplifier in second.
// R10: Branch-to-summing-node switch pair active only while offset null is on.
// R11: C-branch size field is binary, 32 sizes, value equals unit capacitors.
// R12: Second register: bit7 column bus, bit6 comparator bus, bit5 offset null, [4:0] C size.
// R13: Second control registers at indices 82h, 8Ah, 96h, 9Eh, same in both banks.
// R14: Integrator gate switch enable uses both gate bit and offset null bit.
// R15: Gate set: switch closed always without offset null, else only in second phase.
// R16: Internal phases are non-overlapping complementary clocks.
package sca_pkg;
  localparam int NUM_BLK = 4;
  localparam int ADDR_W = 12;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_BLK10_CR1 = 8'h81;
  localparam logic [7:0] IDX_BLK10_CR2 = 8'h82;
  localparam logic [7:0] IDX_BLK12_CR1 = 8'h89;
  localparam logic [7:0] IDX_BLK12_CR2 = 8'h8A;
  localparam logic [7:0] IDX_BLK21_CR1 = 8'h95;
  localparam logic [7:0] IDX_BLK21_CR2 = 8'h96;
  localparam logic [7:0] IDX_BLK23_CR1 = 8'h9D;
  localparam logic [7:0] IDX_BLK23_CR2 = 8'h9E;

  localparam logic [7:0] CR1_IDX [NUM_BLK] = '{IDX_BLK10_CR1, IDX_BLK12_CR1,
                                               IDX_BLK21_CR1, IDX_BLK23_CR1};
  localparam logic [7:0] CR2_IDX [NUM_BLK] = '{IDX_BLK10_CR2, IDX_BLK12_CR2,
                                               IDX_BLK21_CR2, IDX_BLK23_CR2};

  // Field positions
  localparam int CR2_COL_BUS_BIT = 7;
  localparam int CR2_CMP_BUS_BIT = 6;
  localparam int CR2_NULL_BIT = 5;
  localparam int CAP_MSB = 4;
  localparam int CAP_LSB = 0;

  // Reset values
  localparam logic [7:0] CR1_RESET = 8'h00;
  localparam logic [7:0] CR2_RESET = 8'h00;

  // Phase generator: eight pclk cycles per analog period
  localparam logic [2:0] PH_PERIOD_LAST = 3'h7;
  localparam logic [2:0] PH1_START = 3'h1;
  localparam logic [2:0] PH1_END = 3'h2;
  localparam logic [2:0] PH2_START = 3'h5;
  localparam logic [2:0] PH2_LATE = 3'h6;
  localparam logic [2:0] PH2_END = 3'h6;
endpackage

// ---- hdl/sca_switch_ctrl.sv ----
// Register bank and switch timing for four switched-capacitor type A blocks
`timescale 1ns/1ps
`default_nettype none
module sca_switch_ctrl (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sca_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Bits from neighbouring registers, one per block
  input wire logic [3:0] phase_swap_select,
  input wire logic [3:0] integrator_gate_switch,
  // Analog comparator outputs, asynchronous
  input wire logic [3:0] cmp_raw,
  // External phase view
  output logic first_phase,
  output logic second_phase,
  // Switch controls, one bit per block
  output logic [3:0] col_bus_oe_n,
  output logic [3:0] cmp_bus,
  output logic [3:0] short_sw,
  output logic [3:0] branch_gnd_sw,
  output logic [3:0] branch_amp_sw,
  output logic [3:0] sum_node_sw,
  output logic [3:0] integ_sw,
  // Capacitor unit counts, five bits per block
  output logic [19:0] b_branch_cap_size,
  output logic [19:0] c_branch_cap_size
);

  ////////////////////////////////////////////////////////////////////////
  // APB decode
  logic [7:0] cr1 [4];
  logic [7:0] cr2 [4];
  logic [3:0] hit1;
  logic [3:0] hit2;
  logic mapped;
  logic aligned;
  logic [7:0] idx;
  logic [7:0] rd_byte;

  assign idx = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  assign pready = 1'b1;

  always_comb begin
    hit1 = 4'h0;
    hit2 = 4'h0;
    rd_byte = 8'h00;
    for (int i = 0; i < 4; i++) begin
      if (aligned && idx == sca_pkg::CR1_IDX[i]) begin // [R2]
        hit1[i] = 1'b1;
        rd_byte = cr1[i];
      end
      if (aligned && idx == sca_pkg::CR2_IDX[i]) begin // [R13]
        hit2[i] = 1'b1;
        rd_byte = cr2[i];
      end
    end
    mapped = |{hit1, hit2};
  end

  assign pslverr = psel && penable && !mapped;
  assign prdata = (psel && penable && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////
  // Control registers
  logic wr_en;
  assign wr_en = psel && penable && pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        cr1[i] <= sca_pkg::CR1_RESET;
        cr2[i] <= sca_pkg::CR2_RESET;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wr_en && hit1[i]) begin
          cr1[i] <= pwdata[7:0];
        end
        if (wr_en && hit2[i]) begin // [R12]
          cr2[i] <= pwdata[7:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Phase generator
  logic [2:0] ph_cnt;
  logic ph1;
  logic ph2;
  logic ph2_late;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_cnt <= 3'h0;
    end else begin
      ph_cnt <= (ph_cnt == sca_pkg::PH_PERIOD_LAST) ? 3'h0 : ph_cnt + 3'h1;
    end
  end

  // Gap cycles on both sides keep the phases apart
  assign ph1 = (ph_cnt >= sca_pkg::PH1_START) && (ph_cnt <= sca_pkg::PH1_END); // [R16]
  assign ph2 = (ph_cnt >= sca_pkg::PH2_START) && (ph_cnt <= sca_pkg::PH2_END); // [R16]
  assign ph2_late = (ph_cnt == sca_pkg::PH2_LATE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_phase <= 1'b0;
      second_phase <= 1'b0;
    end else begin
      first_phase <= ph1;
      second_phase <= ph2;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Comparator synchronisers
  logic [3:0] cmp_meta;
  logic [3:0] cmp_sync;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_meta <= 4'h0;
      cmp_sync <= 4'h0;
    end else begin
      cmp_meta <= cmp_raw;
      cmp_sync <= cmp_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-block switch timing
  logic [3:0] int_ph1;
  logic [3:0] int_ph2;
  logic [3:0] int_ph2_late;
  logic [3:0] int_ph1_prev;
  logic [3:0] cmp_hold;
  logic [3:0] next_col_oe_n;
  logic [3:0] next_cmp_bus;
  logic [3:0] next_short;
  logic [3:0] next_gnd;
  logic [3:0] next_amp;
  logic [3:0] next_sum;
  logic [3:0] next_integ;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      // Swapped phasing exchanges the two internal phases
      int_ph1[i] = phase_swap_select[i] ? ph2 : ph1;
      int_ph2[i] = phase_swap_select[i] ? ph1 : ph2;
      int_ph2_late[i] = phase_swap_select[i] ? 1'b1 : ph2_late; // [R4]
      next_col_oe_n[i] = !(cr2[i][sca_pkg::CR2_COL_BUS_BIT] && int_ph2_late[i]); // [R3] [R4]
      next_cmp_bus[i] = cr2[i][sca_pkg::CR2_CMP_BUS_BIT] && cmp_hold[i]; // [R5] [R6]
      if (cr2[i][sca_pkg::CR2_NULL_BIT]) begin
        next_short[i] = int_ph1[i]; // [R9]
        next_gnd[i] = int_ph1[i]; // [R9]
        next_amp[i] = int_ph2[i]; // [R9]
        next_sum[i] = 1'b1; // [R10]
        next_integ[i] = integrator_gate_switch[i] && int_ph2[i]; // [R14] [R15]
      end else begin
        next_short[i] = 1'b0; // [R8]
        next_gnd[i] = 1'b0; // [R8]
        next_amp[i] = 1'b1; // [R8]
        next_sum[i] = 1'b0; // [R10]
        next_integ[i] = integrator_gate_switch[i]; // [R14] [R15]
      end
    end
  end

  // Comparator latch, loaded on internal first phase rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_ph1_prev <= 4'h0;
      cmp_hold <= 4'h0;
    end else begin
      int_ph1_prev <= int_ph1;
      for (int i = 0; i < 4; i++) begin
        if (int_ph1[i] && !int_ph1_prev[i]) begin
          cmp_hold[i] <= cmp_sync[i]; // [R7]
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col_bus_oe_n <= 4'hF;
      cmp_bus <= 4'h0;
      short_sw <= 4'h0;
      branch_gnd_sw <= 4'h0;
      branch_amp_sw <= 4'h0;
      sum_node_sw <= 4'h0;
      integ_sw <= 4'h0;
    end else begin
      col_bus_oe_n <= next_col_oe_n;
      cmp_bus <= next_cmp_bus;
      short_sw <= next_short;
      branch_gnd_sw <= next_gnd;
      branch_amp_sw <= next_amp;
      sum_node_sw <= next_sum;
      integ_sw <= next_integ;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Capacitor size fields, plain binary unit counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b_branch_cap_size <= 20'h00000;
      c_branch_cap_size <= 20'h00000;
    end else begin
      for (int i = 0; i < 4; i++) begin
        b_branch_cap_size[i*5 +: 5] <= cr1[i][sca_pkg::CAP_MSB:sca_pkg::CAP_LSB]; // [R1]
        c_branch_cap_size[i*5 +: 5] <= cr2[i][sca_pkg::CAP_MSB:sca_pkg::CAP_LSB]; // [R11]
      end
    end
  end

endmodule
`default_nettype wire

// ---- tb/sca_switch_checker.sv ----
// Port-level assertions for the switch control block
`timescale 1ns/1ps
`default_nettype none
module sca_switch_checker (
  // Clock and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [sca_pkg::ADDR_W-1:0] paddr,
  input wire logic pslverr,
  // Neighbour bits
  input wire logic [3:0] phase_swap_select,
  input wire logic [3:0] integrator_gate_switch,
  // Phases and switches
  input wire logic first_phase,
  input wire logic second_phase,
  input wire logic [3:0] col_bus_oe_n,
  input wire logic [3:0] short_sw,
  input wire logic [3:0] branch_gnd_sw,
  input wire logic [3:0] branch_amp_sw,
  input wire logic [3:0] sum_node_sw,
  input wire logic [3:0] integ_sw
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_ph1;
    first_phase [*2] ##1 !first_phase;
  endsequence
  sequence s_ph2;
    ##2 second_phase [*2];
  endsequence
  a_no_overlap: assert property (!(first_phase && second_phase))
    else $error("phases overlap");
  a_ph_order: assert property ($rose(first_phase) |-> s_ph1 ##0 s_ph2)
    else $error("phase order wrong");
  a_short_gnd: assert property (short_sw[0] |-> branch_gnd_sw[0] && !branch_amp_sw[0])
    else $error("short without ground");
  a_short_sum: assert property (short_sw[0] |-> sum_node_sw[0])
    else $error("short without pair");
  a_null_off: assert property (!sum_node_sw[0] && $past(presetn) |-> branch_amp_sw[0] && !short_sw[0])
    else $error("null off switches wrong");
  a_gate_off: assert property (!integrator_gate_switch[0] [*2] |-> !integ_sw[0])
    else $error("gate switch closed");
  a_integ_ph2: assert property (integ_sw[0] && sum_node_sw[0] && !phase_swap_select[0]
    && !$past(phase_swap_select[0]) |-> second_phase)
    else $error("gate switch outside phase");
  a_col_late: assert property (!col_bus_oe_n[0] && !phase_swap_select[0]
    && !$past(phase_swap_select[0]) |-> second_phase && $past(second_phase))
    else $error("column drive early");
  a_bad_addr: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned not refused");
endmodule
bind sca_switch_ctrl sca_switch_checker chk_u (.pclk, .presetn, .psel, .penable, .paddr,
  .pslverr, .phase_swap_select, .integrator_gate_switch, .first_phase, .second_phase,
  .col_bus_oe_n, .short_sw, .branch_gnd_sw, .branch_amp_sw, .sum_node_sw, .integ_sw);
`default_nettype wire

// ---- tb/sca_analog_model.sv ----
// Comparator stand-in for the analog side
`timescale 1ns/1ps
`default_nettype none
module sca_analog_model (
  // Clock and commanded level
  input wire logic pclk,
  input wire logic [3:0] cmp_level,
  // Comparator outputs
  output logic [3:0] cmp_raw
);
  // Settles one clock after the input moves
  always_ff @(posedge pclk) begin
    cmp_raw <= cmp_level;
  end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the switch control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic pready, pslverr, first_phase, second_phase, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] phase_swap_select = 4'h0, integrator_gate_switch = 4'h0, lvl = 4'h0;
  logic [3:0] cmp_raw, col_bus_oe_n, cmp_bus, short_sw, branch_gnd_sw;
  logic [3:0] branch_amp_sw, sum_node_sw, integ_sw;
  logic [19:0] b_branch_cap_size, c_branch_cap_size;
  logic [7:0] v;
  logic [31:0] cnt [5];
  integer num_errors = 0, check_count = 0, cycles = 0, seed = 32'h1c39d18d, b;
  always #10 pclk = ~pclk;
  sca_switch_ctrl dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .phase_swap_select, .integrator_gate_switch, .cmp_raw,
    .first_phase, .second_phase, .col_bus_oe_n, .cmp_bus, .short_sw, .branch_gnd_sw,
    .branch_amp_sw, .sum_node_sw, .integ_sw, .b_branch_cap_size, .c_branch_cap_size);
  sca_analog_model model_u (.pclk, .cmp_level(lvl), .cmp_raw);
  //////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  // High counts per switch over two analog periods
  task meas;
    logic [4:0] s;
    cnt = '{default: 32'h0};
    repeat (16) begin
      @(posedge pclk);
      s = {integ_sw[b], sum_node_sw[b], branch_amp_sw[b], short_sw[b], !col_bus_oe_n[b]};
      for (int k = 0; k < 5; k++) cnt[k] += 32'(s[k]);
    end
  endtask
  function automatic logic [31:0] exp_cnt(input int k, input logic [7:0] c, input logic s, g);
    case (k)
      0: return !c[7] ? 32'h0 : s ? 32'h10 : 32'h2;
      1: return c[5] ? 32'h4 : 32'h0;
      2: return c[5] ? 32'h4 : 32'h10;
      3: return c[5] ? 32'h10 : 32'h0;
      default: return !g ? 32'h0 : c[5] ? 32'h4 : 32'h10;
    endcase
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    for (b = 0; b < 4; b++) begin
      apb(1'h0, {2'h0, sca_pkg::CR1_IDX[b], 2'h0}, 8'h00);
      chk(rd, 32'h0);
      apb(1'h0, {2'h0, sca_pkg::CR2_IDX[b], 2'h0}, 8'h00);
      chk(rd, 32'h0);
    end
    apb(1'h0, 12'h20C, 8'h00);
    chk({rd[30:0], err}, 32'h1);
    apb(1'h1, 12'h205, 8'hFF);
    chk({31'h0, err}, 32'h1);
    for (int i = 0; i < 40; i++) begin
      b = $unsigned($random(seed)) % 4;
      v = i == 0 ? 8'hFF : i == 1 ? 8'hE0 : 8'($random(seed));
      apb(1'h1, {2'h0, sca_pkg::CR1_IDX[b], 2'h0}, v);
      apb(1'h0, {2'h0, sca_pkg::CR1_IDX[b], 2'h0}, 8'h00);
      chk(rd, {24'h0, v});
      chk(32'(b_branch_cap_size[5*b+:5]), 32'(v[4:0]));
      phase_swap_select <= 4'($random(seed));
      integrator_gate_switch <= 4'($random(seed));
      lvl <= 4'($random(seed));
      v = i == 0 ? 8'h1F : 8'($random(seed));
      apb(1'h1, {2'h0, sca_pkg::CR2_IDX[b], 2'h0}, v);
      apb(1'h0, {2'h0, sca_pkg::CR2_IDX[b], 2'h0}, 8'h00);
      chk(rd, {24'h0, v});
      chk(32'(c_branch_cap_size[5*b+:5]), 32'(v[4:0]));
      repeat (4) @(posedge pclk);
      meas();
      for (int k = 0; k < 5; k++) begin
        chk(cnt[k], exp_cnt(k, v, phase_swap_select[b], integrator_gate_switch[b]));
      end
      chk({31'h0, cmp_bus[b]}, {31'h0, v[6] & lvl[b]});
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
